//--- twm_master.sv
/*
  twm_master: two-wire serial master that downloads defaults from an eeprom after
  reset and runs single-byte reads and writes on request.
  assumes: pins are open-drain with external pull-ups; the pad ring resolves each
  terminal from its _oe; request ports come from logic on sys_clk.
*/
// How it works
// - bus enabled: terminals 3/4 carry serial lines
// - latest reset release samples clock pull-up
// - writing zero to present disables at once
// - clock output only, data both ways, open-drain
// - clock toggles near 60 khz, released when idle
// - start opens, stop closes every transfer
// - data steady while clock is high
// - eight-bit bytes, each followed by acknowledge
// - receiver acknowledges by holding data low
// - software runs only single-byte reads and writes
// - multibyte download runs after link reset
// - write: address, word, data, acknowledges, stop
// - unacknowledged slave address sets bus error
// - read: word, repeated start, byte, nack, stop
// - download acks each byte, nacks the last
// - short protocol drops word address phase
// - slave address write launches one transaction
// - download busy flag held during download
// - download error reports download outcome
`timescale 1ns/100ps
module twm_master #(
  parameter int QTR_CYCLES = twm_pkg::QTR_CYCLES,  // core cycles per quarter bit
  parameter int DL_BYTES   = twm_pkg::DL_BYTES     // bytes fetched by the download
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // device resets from pins, active low
  input  wire logic       link_reset_in_n,
  input  wire logic       global_reset_in_n,
  // shared terminal three (serial data)
  input  wire logic       term3_in,
  output logic            term3_o,
  output logic            term3_oe,
  // shared terminal four (serial clock)
  input  wire logic       term4_in,
  output logic            term4_o,
  output logic            term4_oe,
  // general-purpose side of the shared terminals
  input  wire logic       general_io_three_o,
  input  wire logic       general_io_three_oe,
  output logic            general_io_three_i,
  input  wire logic       general_io_four_o,
  input  wire logic       general_io_four_oe,
  output logic            general_io_four_i,
  // software request
  input  wire logic [7:0] sw_word_addr,
  input  wire logic [7:0] sw_wdata,
  input  wire logic [7:0] sw_slave_byte,
  input  wire logic       sw_slave_wr,
  input  wire logic       sw_present_clr,
  input  wire logic       short_protocol_select,
  // status
  output logic            bus_present_flag,
  output logic            bus_error_flag,
  output logic            request_busy_flag,
  output logic            download_busy_flag,
  output logic            download_error_flag,
  output logic [7:0]      sw_rdata,
  // downloaded bytes
  output logic            dl_byte_valid,
  output logic [7:0]      dl_byte_index,
  output logic [7:0]      dl_byte_data
);

  // ----------------------------------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------------------------------
  localparam int QTR_SAFE = (QTR_CYCLES < 1) ? 1 : QTR_CYCLES;
  localparam logic [twm_pkg::DIV_W-1:0] QTR_LAST = twm_pkg::DIV_W'(QTR_SAFE - 1);
  localparam logic [twm_pkg::CNT_W-1:0] DL_COUNT = twm_pkg::CNT_W'(DL_BYTES);

  logic       rst_meta_r;  // first reset stage
  logic       rst_sync_n;  // released reset used everywhere below
  logic [3:0] pins_s;      // synced term3, term4, global and link resets
  logic       sda_s;       // synced data terminal
  logic       scl_s;       // synced clock terminal
  logic       rst_both_s;  // both device resets released

  // reset asserts at once, releases after two edges
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_n <= rst_meta_r;
    end
  end

  // all pin levels pass two flops before any logic sees them
  twm_sync #(.W(4), .RST_VAL(4'h3)) u_pin_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_sync_n),
    .async_in ({link_reset_in_n, global_reset_in_n, term4_in, term3_in}),
    .sync_out (pins_s)
  );

  assign sda_s      = pins_s[0];
  assign scl_s      = pins_s[1];
  assign rst_both_s = pins_s[2] & pins_s[3];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  twm_pkg::twm_state_e st_r, st_nxt;            // sequencer state
  logic [1:0]  ph_r, ph_nxt;                    // quarter within a bit slot
  logic [3:0]  slot_r, slot_nxt;                // bit slot, 8 is acknowledge
  logic [7:0]  sh_r, sh_nxt;                    // byte shifter
  logic        ack_r, ack_nxt;                  // sampled acknowledge level
  logic [twm_pkg::DIV_W-1:0] div_r, div_nxt;    // quarter divider
  logic        tick;                            // quarter-slot enable pulse
  logic        rel_r, rel_nxt;                  // previous both-released level
  logic        op_rd_r, op_rd_nxt;              // transfer reads
  logic        op_dl_r, op_dl_nxt;              // transfer is the download
  logic        short_r, short_nxt;              // word phase dropped for this transfer
  logic [6:0]  slave_r, slave_nxt;              // slave address of this transfer
  logic [7:0]  word_r, word_nxt;                // word address of this transfer
  logic [7:0]  wdata_r, wdata_nxt;              // data byte to write
  logic [twm_pkg::CNT_W-1:0] left_r, left_nxt;  // download bytes still wanted
  logic        dl_pend_r, dl_pend_nxt;          // download owed after link reset
  logic        present_r, present_nxt;
  logic        berr_r, berr_nxt;
  logic        rbusy_r, rbusy_nxt;
  logic        dbusy_r, dbusy_nxt;
  logic        derr_r, derr_nxt;
  logic [7:0]  rdata_r, rdata_nxt;
  logic        dlv_r, dlv_nxt;
  logic [7:0]  dli_r, dli_nxt;
  logic [7:0]  dld_r, dld_nxt;
  logic        scl_lo, sda_lo;                  // lines pulled low by this state
  logic        t3_o_nxt, t3_oe_nxt, t4_o_nxt, t4_oe_nxt;
  logic        slot_end, nack, more;

  // ----------------------------------------------------------------
  // line drive per state and quarter
  // ----------------------------------------------------------------
  // start: q0 scl lo/sda hi, q1 both hi, q2 sda lo, q3 scl lo
  // stop: q0 both lo, q1 scl hi, q2/q3 sda released
  // bit: data changes only in q0, clock high in q1/q2
  always_comb begin
    scl_lo = 1'b0;
    sda_lo = 1'b0;
    case (st_r)
      twm_pkg::ST_IDLE: begin
        scl_lo = 1'b0;  // clock left released, no toggling
        sda_lo = 1'b0;
      end
      twm_pkg::ST_START, twm_pkg::ST_RSTART: begin
        scl_lo = (ph_r == twm_pkg::PH_FIRST) || (ph_r == twm_pkg::PH_LAST);
        sda_lo = (ph_r == twm_pkg::PH_SAMPLE) || (ph_r == twm_pkg::PH_LAST);
      end
      twm_pkg::ST_STOP: begin
        scl_lo = (ph_r == twm_pkg::PH_FIRST);
        sda_lo = (ph_r == twm_pkg::PH_FIRST) || (ph_r == twm_pkg::PH_RISE);
      end
      twm_pkg::ST_READ: begin
        scl_lo = (ph_r == twm_pkg::PH_FIRST) || (ph_r == twm_pkg::PH_LAST);
        // ack low while more bytes are wanted, nack high on the last
        sda_lo = (slot_r == twm_pkg::ACK_SLOT) && more;
      end
      default: begin
        scl_lo = (ph_r == twm_pkg::PH_FIRST) || (ph_r == twm_pkg::PH_LAST);
        // msb first, released during the slave's acknowledge
        sda_lo = (slot_r != twm_pkg::ACK_SLOT) && !sh_r[7];
      end
    endcase
  end

  // ----------------------------------------------------------------
  // terminal muxing: serial lines or general-purpose pins
  // ----------------------------------------------------------------
  // open-drain while present: the pin value is always low, only the enable moves
  always_comb begin
    if (present_r) begin
      t3_o_nxt  = 1'b0;
      t3_oe_nxt = sda_lo;  // data line, both directions
      t4_o_nxt  = 1'b0;
      t4_oe_nxt = scl_lo;  // clock line, output only
    end else begin
      t3_o_nxt  = general_io_three_o;  // general-purpose use restored
      t3_oe_nxt = general_io_three_oe;
      t4_o_nxt  = general_io_four_o;
      t4_oe_nxt = general_io_four_oe;
    end
  end

  // ----------------------------------------------------------------
  // quarter divider and sequencer next state
  // ----------------------------------------------------------------
  assign tick     = (div_r == QTR_LAST);
  assign slot_end = tick && (ph_r == twm_pkg::PH_LAST);
  assign more     = op_dl_r && (left_r > twm_pkg::CNT_W'(1));
  assign nack     = ack_r;  // high level in the ack slot means no acknowledge

  always_comb begin
    st_nxt      = st_r;
    ph_nxt      = ph_r;
    slot_nxt    = slot_r;
    sh_nxt      = sh_r;
    ack_nxt     = ack_r;
    div_nxt     = tick ? '0 : div_r + twm_pkg::DIV_W'(1);  // four quarters per bit
    rel_nxt     = rst_both_s;
    op_rd_nxt   = op_rd_r;
    op_dl_nxt   = op_dl_r;
    short_nxt   = short_r;
    slave_nxt   = slave_r;
    word_nxt    = word_r;
    wdata_nxt   = wdata_r;
    left_nxt    = left_r;
    dl_pend_nxt = dl_pend_r;
    present_nxt = present_r;
    berr_nxt    = berr_r;
    rbusy_nxt   = rbusy_r;
    dbusy_nxt   = dbusy_r;
    derr_nxt    = derr_r;
    rdata_nxt   = rdata_r;
    dlv_nxt     = 1'b0;
    dli_nxt     = dli_r;
    dld_nxt     = dld_r;

    // software clear of the present flag; a detect in the same cycle wins
    if (sw_present_clr) begin
      present_nxt = 1'b0;
    end
    // latest of the two reset releases: look for the clock pull-up
    if (rst_both_s && !rel_r) begin
      present_nxt = scl_s;
      dl_pend_nxt = scl_s;  // download owed once detected
    end

    if (!rst_both_s || !present_nxt) begin
      // disabled or held in reset: go idle and drop both busy flags at once
      st_nxt    = twm_pkg::ST_IDLE;
      rbusy_nxt = 1'b0;
      dbusy_nxt = 1'b0;
      if (!rst_both_s) begin
        dl_pend_nxt = 1'b0;
      end
    end else if (st_r == twm_pkg::ST_IDLE) begin
      ph_nxt   = twm_pkg::PH_FIRST;
      slot_nxt = '0;
      div_nxt  = '0;  // first quarter of a transfer runs full length
      if (dl_pend_r) begin
        // automatic multibyte read of the load map
        st_nxt      = twm_pkg::ST_START;
        dl_pend_nxt = 1'b0;
        dbusy_nxt   = 1'b1;
        derr_nxt    = 1'b0;
        op_dl_nxt   = 1'b1;
        op_rd_nxt   = 1'b1;
        short_nxt   = short_protocol_select;
        slave_nxt   = twm_pkg::EEPROM_ADDR7;
        word_nxt    = twm_pkg::DL_FIRST_WORD;
        left_nxt    = DL_COUNT;
        dli_nxt     = '0;
      end else if (sw_slave_wr) begin
        // slave-address write launches one single-byte transfer
        st_nxt    = twm_pkg::ST_START;
        rbusy_nxt = 1'b1;
        berr_nxt  = 1'b0;
        op_dl_nxt = 1'b0;
        op_rd_nxt = sw_slave_byte[0];
        short_nxt = short_protocol_select;
        slave_nxt = sw_slave_byte[7:1];
        word_nxt  = sw_word_addr;
        wdata_nxt = sw_wdata;
        left_nxt  = twm_pkg::CNT_W'(1);
      end
    end else if (tick) begin
      ph_nxt = ph_r + 2'h1;
      // sample on the last clock-high quarter
      if (ph_r == twm_pkg::PH_SAMPLE) begin
        if (slot_r == twm_pkg::ACK_SLOT) begin
          ack_nxt = sda_s;
        end else if (st_r == twm_pkg::ST_READ) begin
          sh_nxt = {sh_r[6:0], sda_s};  // slave sends msb first
        end
      end
      if (slot_end) begin
        slot_nxt = slot_r + 4'h1;
        if ((st_r != twm_pkg::ST_READ) && (slot_r != twm_pkg::ACK_SLOT)) begin
          sh_nxt = {sh_r[6:0], 1'b0};
        end
        case (st_r)
          twm_pkg::ST_START: begin
            slot_nxt = '0;
            if (op_rd_r && short_r) begin
              st_nxt = twm_pkg::ST_ADDR_R;  // no word phase, read at once
              sh_nxt = {slave_r, twm_pkg::DIR_READ};
            end else begin
              st_nxt = twm_pkg::ST_ADDR_W;
              sh_nxt = {slave_r, twm_pkg::DIR_WRITE};
            end
          end
          twm_pkg::ST_RSTART: begin
            slot_nxt = '0;
            st_nxt   = twm_pkg::ST_ADDR_R;
            sh_nxt   = {slave_r, twm_pkg::DIR_READ};
          end
          twm_pkg::ST_ADDR_W, twm_pkg::ST_WORD, twm_pkg::ST_DATA_W,
          twm_pkg::ST_ADDR_R: begin
            if (slot_r == twm_pkg::ACK_SLOT) begin
              slot_nxt = '0;
              if (nack) begin
                // missing acknowledge anywhere: flag it and close
                st_nxt = twm_pkg::ST_STOP;
                if (op_dl_r) begin
                  derr_nxt = 1'b1;
                end else begin
                  berr_nxt = 1'b1;
                end
              end else if (st_r == twm_pkg::ST_ADDR_R) begin
                st_nxt = twm_pkg::ST_READ;
              end else if (st_r == twm_pkg::ST_DATA_W) begin
                st_nxt = twm_pkg::ST_STOP;  // final ack then stop
              end else if ((st_r == twm_pkg::ST_ADDR_W) && !short_r) begin
                st_nxt = twm_pkg::ST_WORD;
                sh_nxt = word_r;
              end else if ((st_r == twm_pkg::ST_WORD) && op_rd_r) begin
                st_nxt = twm_pkg::ST_RSTART;
              end else begin
                st_nxt = twm_pkg::ST_DATA_W;  // short write skips the word
                sh_nxt = wdata_r;
              end
            end
          end
          twm_pkg::ST_READ: begin
            if (slot_r == twm_pkg::ACK_SLOT) begin
              slot_nxt = '0;
              left_nxt = left_r - twm_pkg::CNT_W'(1);
              if (op_dl_r) begin
                dlv_nxt = 1'b1;
                dld_nxt = sh_r;
              end else begin
                rdata_nxt = sh_r;
              end
              // keep reading while bytes are wanted
              st_nxt = more ? twm_pkg::ST_READ : twm_pkg::ST_STOP;
            end
          end
          twm_pkg::ST_STOP: begin
            st_nxt    = twm_pkg::ST_IDLE;  // lines released, clock idle
            rbusy_nxt = 1'b0;
            dbusy_nxt = 1'b0;
          end
          default: begin
            st_nxt = twm_pkg::ST_IDLE;
          end
        endcase
      end
    end
    // index advances after each delivered byte
    if (dlv_r) begin
      dli_nxt = dli_r + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_r      <= twm_pkg::ST_IDLE;
      ph_r      <= '0;
      slot_r    <= '0;
      sh_r      <= '0;
      ack_r     <= 1'b1;
      div_r     <= '0;
      rel_r     <= 1'b0;
      op_rd_r   <= 1'b0;
      op_dl_r   <= 1'b0;
      short_r   <= 1'b0;
      slave_r   <= '0;
      word_r    <= '0;
      wdata_r   <= '0;
      left_r    <= '0;
      dl_pend_r <= 1'b0;
      present_r <= 1'b0;
      berr_r    <= 1'b0;
      rbusy_r   <= 1'b0;
      dbusy_r   <= 1'b0;
      derr_r    <= 1'b0;
      rdata_r   <= '0;
      dlv_r     <= 1'b0;
      dli_r     <= '0;
      dld_r     <= '0;
      term3_o   <= 1'b0;
      term3_oe  <= 1'b0;
      term4_o   <= 1'b0;
      term4_oe  <= 1'b0;
      general_io_three_i <= 1'b1;
      general_io_four_i  <= 1'b1;
    end else begin
      st_r      <= st_nxt;
      ph_r      <= ph_nxt;
      slot_r    <= slot_nxt;
      sh_r      <= sh_nxt;
      ack_r     <= ack_nxt;
      div_r     <= div_nxt;
      rel_r     <= rel_nxt;
      op_rd_r   <= op_rd_nxt;
      op_dl_r   <= op_dl_nxt;
      short_r   <= short_nxt;
      slave_r   <= slave_nxt;
      word_r    <= word_nxt;
      wdata_r   <= wdata_nxt;
      left_r    <= left_nxt;
      dl_pend_r <= dl_pend_nxt;
      present_r <= present_nxt;
      berr_r    <= berr_nxt;
      rbusy_r   <= rbusy_nxt;
      dbusy_r   <= dbusy_nxt;
      derr_r    <= derr_nxt;
      rdata_r   <= rdata_nxt;
      dlv_r     <= dlv_nxt;
      dli_r     <= dli_nxt;
      dld_r     <= dld_nxt;
      term3_o   <= t3_o_nxt;
      term3_oe  <= t3_oe_nxt;
      term4_o   <= t4_o_nxt;
      term4_oe  <= t4_oe_nxt;
      general_io_three_i <= sda_s;
      general_io_four_i  <= scl_s;
    end
  end

  // ----------------------------------------------------------------
  // status outputs, all straight from flops
  // ----------------------------------------------------------------
  assign bus_present_flag    = present_r;
  assign bus_error_flag      = berr_r;
  assign request_busy_flag   = rbusy_r;
  assign download_busy_flag  = dbusy_r;
  assign download_error_flag = derr_r;
  assign sw_rdata            = rdata_r;
  assign dl_byte_valid       = dlv_r;
  assign dl_byte_index       = dli_r;
  assign dl_byte_data        = dld_r;

endmodule

//--- twm_pkg.sv
/*
  twm_pkg: shared constants and types of the two-wire eeprom master.
  assumes: a single 125 mhz core clock; all users reference names as twm_pkg::name.
*/
package twm_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int SYS_CLK_HZ     = 125_000_000;  // core clock rate
  localparam int SCL_HZ         = 60_000;       // target serial clock rate
  localparam int PHASES_PER_BIT = 4;            // quarter slots in one serial bit
  // longest quarter slot that keeps the clock at or above the target rate
  localparam int QTR_CYCLES     = SYS_CLK_HZ / (SCL_HZ * PHASES_PER_BIT);
  localparam int DIV_W          = 16;           // width of the quarter divider

  // ----------------------------------------------------------------
  // bus addressing and download shape
  // ----------------------------------------------------------------
  localparam logic [6:0] EEPROM_ADDR7  = 7'h50;  // a0h once the direction bit is added
  localparam logic       DIR_WRITE     = 1'h0;   // direction bit for a write
  localparam logic       DIR_READ      = 1'h1;   // direction bit for a read
  localparam logic [7:0] DL_FIRST_WORD = 8'h00;  // download starts at word zero
  localparam int         DL_BYTES      = 40;     // words 00h..27h of the load map
  localparam int         CNT_W         = 8;      // width of byte counters

  // ----------------------------------------------------------------
  // bit slot layout
  // ----------------------------------------------------------------
  localparam logic [3:0] ACK_SLOT  = 4'h8;  // ninth slot of a byte is the acknowledge
  localparam logic [1:0] PH_FIRST  = 2'h0;  // clock low, data may change
  localparam logic [1:0] PH_RISE   = 2'h1;  // clock released
  localparam logic [1:0] PH_SAMPLE = 2'h2;  // clock high, data sampled at its end
  localparam logic [1:0] PH_LAST   = 2'h3;  // last quarter, slot decision taken

  // ----------------------------------------------------------------
  // sequencer states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [8:0] {
    ST_IDLE   = 9'h001,
    ST_START  = 9'h002,
    ST_ADDR_W = 9'h004,
    ST_WORD   = 9'h008,
    ST_DATA_W = 9'h010,
    ST_RSTART = 9'h020,
    ST_ADDR_R = 9'h040,
    ST_READ   = 9'h080,
    ST_STOP   = 9'h100
  } twm_state_e;

endpackage

//--- twm_sync.sv
/*
  twm_sync: two-flop synchroniser for a vector of independent levels.
  assumes: each bit is a slow level from outside the sys_clk domain; bits are not
  related to one another, so no word coherence is promised.
*/
`timescale 1ns/100ps
module twm_sync #(
  parameter int         W        = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  // levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  // ----------------------------------------------------------------
  // two stages
  // ----------------------------------------------------------------
  logic [W-1:0] meta_r;  // first stage, read only by the second

  // the first stage may go metastable; only sync_out feeds logic
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r   <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

//--- twm_properties.sv
/* twm_properties: port checks for twm_master.
   assumes: bound to each twm_master; a released clock pin reads high. */
`timescale 1ns/100ps
module twm_properties #(
  parameter int QTR_CYCLES = 4
) (
  // clock, reset, pins, requests and status
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic term3_o,
  input wire logic term3_oe,
  input wire logic term4_o,
  input wire logic term4_oe,
  input wire logic sw_slave_wr,
  input wire logic sw_present_clr,
  input wire logic bus_present_flag,
  input wire logic request_busy_flag,
  input wire logic download_busy_flag,
  input wire logic dl_byte_valid
);
  // ----
  // run length of the released clock inside a transfer
  // ----
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic        bsy;
  logic [15:0] hi_r, hi_nxt;
  assign bsy = request_busy_flag | download_busy_flag;
  always_comb hi_nxt = (bsy && !term4_oe) ? hi_r + 16'h1 : 16'h0;
  always_ff @(posedge sys_clk or negedge rst_n) if (!rst_n) hi_r <= 16'h0;
    else hi_r <= hi_nxt;
  property p_idle; bus_present_flag && !bsy |-> !term4_oe; endproperty
  a_idle: assert property (p_idle) else $error("clock held while idle");
  property p_od; bus_present_flag && $past(bus_present_flag) |-> !term3_o && !term4_o; endproperty
  a_od: assert property (p_od) else $error("pin driven high");
  property p_dl; dl_byte_valid |-> download_busy_flag; endproperty
  a_dl: assert property (p_dl) else $error("byte outside download");
  property p_go; sw_slave_wr && bus_present_flag && !bsy |=> request_busy_flag; endproperty
  a_go: assert property (p_go) else $error("launch lost");
  property p_sw; $rose(request_busy_flag) |-> $past(sw_slave_wr); endproperty
  a_sw: assert property (p_sw) else $error("busy without launch");
  property p_off; sw_present_clr |=> !bus_present_flag; endproperty
  a_off: assert property (p_off) else $error("present kept");
  property p_rate; $rose(term4_oe) && bus_present_flag && hi_r > 16'h2
    |-> hi_r == 16'(2 * QTR_CYCLES); endproperty
  a_rate: assert property (p_rate) else $error("clock high time off");
  sequence s_steady; ($stable(term3_oe) || !bus_present_flag) [*3]; endsequence
  property p_hold; $fell(term4_oe) && bus_present_flag |-> ##1 s_steady; endproperty
  a_hold: assert property (p_hold) else $error("data moved in clock high");
endmodule
bind twm_master twm_properties #(.QTR_CYCLES(QTR_CYCLES)) chk_u (.*);

//--- twm_eeprom.sv
/* twm_eeprom: behavioural serial eeprom slave at address 7'h50.
   assumes: the bench resolves both open-drain lines; drv high pulls data low. */
`timescale 1ns/100ps
module twm_eeprom (
  // bus lines, refusal switch, data pull-down
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic nak,
  output logic      drv
);
  // ----
  // byte framing
  // ----
  logic [7:0] mem [256];
  logic [7:0] sh, ptr;
  int         b = 0, k = 0;
  logic       on = 0, tx = 0;
  initial drv = 0;
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h3c;
  // start opens a frame, stop closes it
  always @(negedge sda) if (scl) begin
    on = 1;
    tx = 0;
    b = -1;
    k = 0;
  end
  always @(posedge sda) if (scl) on = 0;
  // sample on the rising clock; a master nack ends sending
  always @(posedge scl) if (on && b < 8) sh = {sh[6:0], sda};
    else if (on && tx && sda) on = 0;
  // eight bits then one ack slot, changes only while clock is low
  always @(negedge scl) if (on) begin
    b++;
    if (b == 9 && k == 0) tx = sh[0];
    else if (b == 9 && tx) ptr++;
    else if (b == 9 && k == 1) ptr = sh;
    else if (b == 9) mem[ptr++] = sh;
    if (b == 9) k++;
    b = b % 9;
    // ack own address and taken bytes, send msb first
    drv = (b == 8) ? !tx && !nak && (k > 0 || sh[7:1] == 7'h50) : tx && !mem[ptr][7 - b];
  end
endmodule

//--- two_wire_eeprom_master_test.sv
/* two_wire_eeprom_master_test: runs twm_master against the eeprom model.
   assumes: pull-ups on both lines; four-cycle quarters, four-byte download. */
`timescale 1ns/100ps
module two_wire_eeprom_master_test;
  logic sys_clk = 0, rst_n = 0, link_reset_in_n = 0, global_reset_in_n = 0, nak = 0, drv;
  logic general_io_three_o = 0, general_io_three_oe = 0, general_io_four_o = 0;
  logic general_io_four_oe = 0, sw_slave_wr = 0, sw_present_clr = 0, short_protocol_select = 0;
  logic [7:0] sw_word_addr = 0, sw_wdata = 0, sw_slave_byte = 0;
  logic [7:0] sw_rdata, dl_byte_index, dl_byte_data;
  logic term3_o, term3_oe, term4_o, term4_oe, general_io_three_i, general_io_four_i;
  logic bus_present_flag, bus_error_flag, request_busy_flag, download_busy_flag;
  logic download_error_flag, dl_byte_valid;
  wire  term4_in = term4_oe ? term4_o : 1'h1;
  wire  term3_in = (term3_oe ? term3_o : 1'h1) && !drv;
  int   mismatches = 0, tests_run = 0, n, dl_n = 0;
  typedef struct {logic rd, sp; logic [7:0] w, d, x;} twm_row_s;
  // long write, long read, short read, short write, short read
  twm_row_s rows [5] = '{'{0, 0, 8'h10, 8'ha5, 0}, '{1, 0, 8'h10, 0, 8'ha5},
    '{1, 1, 0, 0, 8'ha5}, '{0, 1, 0, 8'h40, 8'ha5}, '{1, 1, 0, 0, 8'h7c}};
  always #4 sys_clk = !sys_clk;
  twm_master #(.QTR_CYCLES(4), .DL_BYTES(4)) dut_u (.*);
  twm_eeprom mdl_u (.scl(term4_in), .sda(term3_in), .nak(nak), .drv(drv));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    if (got !== exp) mismatches++;
  endtask
  task automatic conclude();
    $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // optional launch, then a bounded wait for both busy flags to drop
  task automatic run(input logic go, rd, sp, input logic [7:0] w, d);
    @(posedge sys_clk) #1 {sw_word_addr, sw_wdata, sw_slave_byte} = {w, d, 7'h50, rd};
    short_protocol_select = sp;
    sw_slave_wr = go;
    @(posedge sys_clk) #1 sw_slave_wr = 0;
    for (n = 0; n < 4000 && (request_busy_flag | download_busy_flag) !== 1'h0; n++)
      @(posedge sys_clk) #1;
    mismatches += (n == 4000);
    if (n == 4000) conclude();
  endtask
  // downloaded bytes arrive in order with the stored pattern
  always @(negedge sys_clk) if (dl_byte_valid === 1'h1) begin
    chk(dl_byte_index, 8'(dl_n));
    chk(dl_byte_data, 8'(dl_n) ^ 8'h3c);
    dl_n++;
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    #1 rst_n = 1;
    global_reset_in_n = 1;
    repeat (4) @(posedge sys_clk);
    #1 link_reset_in_n = 1;
    repeat (20) @(posedge sys_clk);
    run(0, 0, 0, 0, 0);
    chk(bus_present_flag, 8'h1);
    chk(8'(dl_n), 8'h4);
    chk(download_error_flag, 8'h0);
    $display("download test done");
    foreach (rows[i]) begin
      run(1, rows[i].rd, rows[i].sp, rows[i].w, rows[i].d);
      chk(bus_error_flag, 8'h0);
      chk(sw_rdata, rows[i].x);
      $display("row %0d done", i);
    end
    nak = 1;
    run(1, 0, 0, 8'h01, 8'h02);
    chk(bus_error_flag, 8'h1);
    nak = 0;
    run(1, 1, 0, 8'h01, 0);
    chk(sw_rdata, 8'h3d);
    $display("nack test done");
    // link reset pulse mid-run: a refused download must report failure
    nak = 1;
    link_reset_in_n = 0;
    repeat (4) @(posedge sys_clk);
    #1 link_reset_in_n = 1;
    repeat (8) @(posedge sys_clk);
    run(0, 0, 0, 0, 0);
    chk(download_error_flag, 8'h1);
    chk(8'(dl_n), 8'h4);
    nak = 0;
    $display("reload test done");
    sw_slave_wr = 1;
    repeat (90) @(posedge sys_clk);
    #1 sw_present_clr = 1;
    general_io_four_oe = 1;
    @(posedge sys_clk) #1 sw_present_clr = 0;
    run(0, 0, 0, 0, 0);
    repeat (3) @(posedge sys_clk) #1;
    chk(bus_present_flag, 8'h0);
    chk(term4_oe, 8'h1);
    chk({general_io_three_i, general_io_four_i}, 8'h2);
    $display("disable test done");
    conclude();
  end
endmodule
